/* File: fid_pkg.sv */
// constants, types and decode helpers for the id, security and lock command block
package fid_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OPC_QUAD_ID   = 8'h94;
  localparam logic [7:0] OPC_DUAL_ID   = 8'h92;
  localparam logic [7:0] OPC_UID       = 8'h4b;
  localparam logic [7:0] OPC_JEDEC     = 8'h9f;
  localparam logic [7:0] OPC_PTAB      = 8'h5a;
  localparam logic [7:0] OPC_SREG_ERASE = 8'h44;
  localparam logic [7:0] OPC_SREG_PROG  = 8'h42;
  localparam logic [7:0] OPC_SREG_READ  = 8'h48;
  localparam logic [7:0] OPC_BLK_LOCK  = 8'h36;

  // ==========================================================
  // frame marks, in rising sck edges since chip select fell
  localparam logic [6:0] CYC_OPC_END    = 7'h08;
  localparam logic [6:0] CYC_ADDR_END   = 7'h20;
  localparam logic [6:0] CYC_STD_DATA   = 7'h28;
  localparam logic [6:0] CYC_DUAL_ADDR  = 7'h14;
  localparam logic [6:0] CYC_DUAL_DATA  = 7'h18;
  localparam logic [6:0] CYC_QUAD_ADDR  = 7'h0e;
  localparam logic [6:0] CYC_QUAD_DATA  = 7'h14;
  localparam logic [6:0] CYC_MAX        = 7'h7f;

  // ==========================================================
  // security registers and timing
  localparam logic [3:0] SECREG_FIRST   = 4'h1;
  localparam logic [3:0] SECREG_LAST    = 4'h3;
  localparam int         CLK_PERIOD_NS  = 50;
  localparam int         SECURITY_ERASE_TIME_US = 100;
  localparam int         SECURITY_ERASE_CYCLES  =
    (SECURITY_ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [11:0] ERASE_LAST    = 12'(SECURITY_ERASE_CYCLES - 1);
  localparam logic        BLOCK_LOCK_RST = 1'b1;

  // ==========================================================
  // output lane enables per bus width
  localparam logic [3:0] OE_SINGLE = 4'b0010;
  localparam logic [3:0] OE_DUAL   = 4'b0011;
  localparam logic [3:0] OE_QUAD   = 4'b1111;

  typedef enum logic [1:0] {
    FID_W1 = 2'b00,
    FID_W2 = 2'b01,
    FID_W4 = 2'b10
  } fid_width_t;

  typedef enum logic {
    ER_IDLE = 1'b0,
    ER_RUN  = 1'b1
  } fid_erase_t;

  // 1..3 for a legal security register address, 0 otherwise
  function automatic logic [1:0] secreg_sel(input logic [23:0] a);
    secreg_sel = 2'b00;
    if (a[23:16] == 8'h00 && a[11:8] == 4'h0 &&
        a[15:12] >= SECREG_FIRST && a[15:12] <= SECREG_LAST) begin
      secreg_sel = a[13:12];
    end
  endfunction

  function automatic logic sel_locked(input logic [1:0] sel, input logic [2:0] lb);
    sel_locked = (sel == 2'b00) ? 1'b1 : lb[2'(sel - 2'b01)];
  endfunction

  // parameter table: signature header, rest erased
  function automatic logic [7:0] ptab_byte(input logic [7:0] a);
    unique case (a)
      8'h00:   ptab_byte = 8'h53;
      8'h01:   ptab_byte = 8'h46;
      8'h02:   ptab_byte = 8'h44;
      8'h03:   ptab_byte = 8'h50;
      default: ptab_byte = 8'hff;
    endcase
  endfunction

endpackage

/* File: fid_mem_if.sv */
// port bundle between the command logic and the security register store
`timescale 1ns/100ps
interface fid_mem_if;
  logic       we;
  logic       erase;
  logic       re;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl  (output we, erase, re, addr, wdata, input rdata);
  modport store (input we, erase, re, addr, wdata, output rdata);
endinterface

/* File: fid_secmem.sv */
// security register store: erase sets a byte to ones, program can only clear bits
`timescale 1ns/100ps
module fid_secmem #(
  parameter int DEPTH = 1024
) (
  input wire logic   clk,
  fid_mem_if.store   m
);
  import fid_pkg::*;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  // no reset: contents model non-volatile cells
  always_ff @(posedge clk) begin
    if (m.we) begin
      mem_q[m.addr] <= m.erase ? 8'hff : (mem_q[m.addr] & m.wdata);
    end
    if (m.re) begin
      rdata_q <= mem_q[m.addr];
    end
  end

  assign m.rdata = rdata_q;
endmodule

/* File: fid_cmd_top.sv */
// serial command logic for id reads, parameter table, security registers, block lock
`timescale 1ns/100ps
module fid_cmd_top #(
  parameter int           LOCK_BLOCKS   = 256,
  parameter logic [7:0]   MAKER_CODE    = 8'h5c,  // arbitrary value
  parameter logic [7:0]   PART_CODE     = 8'h21,  // arbitrary value
  parameter logic [7:0]   MEM_TYPE      = 8'h33,  // arbitrary value
  parameter logic [7:0]   CAPACITY_CODE = 8'h17,  // arbitrary value
  parameter logic [63:0]  UNIQUE_ID     = 64'h0123_4567_89ab_cdef  // arbitrary value
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic [3:0]             io_i,
  output logic [3:0]                  io_o,
  output logic [3:0]                  io_oe,
  input  wire logic                   write_enable_latch,
  input  wire logic                   busy_other,
  input  wire logic [2:0]             otp_lock_bits,
  input  wire logic                   protection_scheme_select,
  input  wire logic                   protect_complement,
  input  wire logic                   sector_granularity_select,
  input  wire logic                   top_bottom_select,
  input  wire logic [2:0]             protect_range_bits,
  output logic                        busy,
  output logic                        write_enable_clear,
  output logic [LOCK_BLOCKS-1:0]      block_protect,
  output fid_pkg::fid_erase_t         erase_state
);
  import fid_pkg::*;

  localparam int LIW = $clog2(LOCK_BLOCKS);

  // ==========================================================
  // link side, clocked by sck and framed by chip select
  logic        frame_rst_n;
  logic [6:0]  cyc_q, cyc_d;
  logic [7:0]  opc_q;
  logic [23:0] addr_q, addr_d;
  logic [7:0]  din_q;
  logic [2:0]  bitc_q;
  logic        rd_ok_q, first_q;
  logic        busy_s1_q, busy_s2_q;
  logic        armed_q, arm_tog_q, pg_tog_q;
  logic [7:0]  hold_opc_q;
  logic [23:0] hold_addr_q;
  logic [9:0]  pg_addr_q, pg_addr_d;
  logic [7:0]  pg_data_q;
  logic        addr_phase, in_data, byte_done, arm_now;
  logic [1:0]  sr_sel;

  // frame state clears whenever chip select is high
  assign frame_rst_n = arst_n & ~cs_n;
  assign cyc_d       = (cyc_q == CYC_MAX) ? cyc_q : cyc_q + 7'h01;
  assign sr_sel      = secreg_sel(addr_q);

  assign addr_phase = (cyc_q >= CYC_OPC_END) &&
                      (opc_q == OPC_QUAD_ID ? cyc_q < CYC_QUAD_ADDR :
                       opc_q == OPC_DUAL_ID ? cyc_q < CYC_DUAL_ADDR :
                                              cyc_q < CYC_ADDR_END);
  assign addr_d = (opc_q == OPC_QUAD_ID) ? {addr_q[19:0], io_i} :
                  (opc_q == OPC_DUAL_ID) ? {addr_q[21:0], io_i[1:0]} :
                                           {addr_q[22:0], io_i[0]};

  assign in_data   = (cyc_q >= CYC_ADDR_END) && (opc_q == OPC_SREG_PROG);
  assign byte_done = in_data && (bitc_q == 3'h7);
  // last address bit lands on this edge; anything later disarms
  assign arm_now   = (cyc_q == CYC_ADDR_END - 7'h01);
  assign pg_addr_d = first_q ? {sr_sel, addr_q[7:0]}
                             : {pg_addr_q[9:8], pg_addr_q[7:0] + 8'h01};

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cyc_q   <= '0;
      opc_q   <= '0;
      addr_q  <= '0;
      din_q   <= '0;
      bitc_q  <= '0;
      rd_ok_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      cyc_q <= cyc_d;
      if (cyc_q < CYC_OPC_END) opc_q <= {opc_q[6:0], io_i[0]};
      if (addr_phase) addr_q <= addr_d;
      if (cyc_q == CYC_OPC_END - 7'h01) rd_ok_q <= ~busy_s2_q;
      if (in_data) din_q <= {din_q[6:0], io_i[0]};
      if (in_data) bitc_q <= bitc_q + 3'h1;
      if (byte_done) first_q <= 1'b0;
    end
  end

  // hand-off registers survive chip select so the core can read them after it rises
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      busy_s1_q   <= 1'b0;
      busy_s2_q   <= 1'b0;
      armed_q     <= 1'b0;
      arm_tog_q   <= 1'b0;
      hold_opc_q  <= '0;
      hold_addr_q <= '0;
      pg_tog_q    <= 1'b0;
      pg_addr_q   <= '0;
      pg_data_q   <= '0;
    end else begin
      busy_s1_q <= busy;
      busy_s2_q <= busy_s1_q;
      armed_q   <= frame_rst_n & arm_now;
      if (arm_now) begin
        arm_tog_q   <= ~arm_tog_q;
        hold_opc_q  <= opc_q;
        hold_addr_q <= addr_d;
      end
      if (byte_done) begin
        pg_tog_q  <= ~pg_tog_q;
        pg_addr_q <= pg_addr_d;
        pg_data_q <= {din_q[6:0], io_i[0]};
      end
    end
  end

  // ==========================================================
  // link output, launched on falling sck
  fid_width_t  wid;
  logic [6:0]  dstart;
  logic        known, out_ok, active, load, rd_req;
  logic [3:0]  step, oe_now, obits_q;
  logic [7:0]  osh_q, ptr_q, byte_now, jedec_byte, id_byte, uid_byte;
  logic [2:0]  bidx_q, bidx_next;
  logic [3:0]  io_o_q, io_oe_q;
  logic        rd_tog_q;
  logic [9:0]  rd_addr_q;
  logic [7:0]  core_rdata;

  function automatic logic [3:0] lane_bits(input logic [7:0] b, input fid_width_t w);
    unique case (w)
      FID_W1: lane_bits = {2'b00, b[7], 1'b0};
      FID_W2: lane_bits = {2'b00, b[7:6]};
      FID_W4: lane_bits = b[7:4];
      default: lane_bits = 4'h0;
    endcase
  endfunction

  assign wid    = (opc_q == OPC_QUAD_ID) ? FID_W4 :
                  (opc_q == OPC_DUAL_ID) ? FID_W2 : FID_W1;
  assign step   = (wid == FID_W4) ? 4'h4 : (wid == FID_W2) ? 4'h2 : 4'h1;
  assign oe_now = (wid == FID_W4) ? OE_QUAD : (wid == FID_W2) ? OE_DUAL : OE_SINGLE;
  assign dstart = (opc_q == OPC_JEDEC)   ? CYC_OPC_END :
                  (opc_q == OPC_DUAL_ID) ? CYC_DUAL_DATA :
                  (opc_q == OPC_QUAD_ID) ? CYC_QUAD_DATA :
                                           CYC_STD_DATA;
  assign known  = (opc_q == OPC_JEDEC) || (opc_q == OPC_DUAL_ID) ||
                  (opc_q == OPC_QUAD_ID) || (opc_q == OPC_UID) ||
                  (opc_q == OPC_PTAB) || (opc_q == OPC_SREG_READ);
  assign out_ok = known && (opc_q != OPC_SREG_READ || (rd_ok_q && sr_sel != 2'b00));
  assign active = out_ok && (cyc_q >= dstart);
  assign load   = active && (obits_q == 4'h0);

  // address bit 0 swaps which code leads
  assign id_byte    = (bidx_q[0] ^ addr_q[0]) ? PART_CODE : MAKER_CODE;
  assign jedec_byte = (bidx_q == 3'h0) ? MAKER_CODE :
                      (bidx_q == 3'h1) ? MEM_TYPE : CAPACITY_CODE;
  assign uid_byte   = 8'(UNIQUE_ID >> {~bidx_q, 3'b000});
  assign byte_now   = (opc_q == OPC_JEDEC) ? jedec_byte :
                      (opc_q == OPC_UID)   ? uid_byte :
                      (opc_q == OPC_PTAB)  ? ptab_byte(ptr_q) :
                      (opc_q == OPC_SREG_READ) ? core_rdata : id_byte;
  assign bidx_next  = (opc_q == OPC_JEDEC && bidx_q == 3'h2) ? 3'h0 : bidx_q + 3'h1;
  assign rd_req     = (opc_q == OPC_SREG_READ) && out_ok &&
                      ((cyc_q == CYC_ADDR_END) || load);

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      obits_q <= '0;
      osh_q   <= '0;
      io_o_q  <= '0;
      io_oe_q <= '0;
      bidx_q  <= '0;
      ptr_q   <= '0;
    end else begin
      io_oe_q <= active ? oe_now : 4'h0;
      if (load) begin
        osh_q   <= byte_now << step;
        io_o_q  <= lane_bits(byte_now, wid);
        obits_q <= 4'h8 - step;
        bidx_q  <= bidx_next;
        ptr_q   <= ptr_q + 8'h01;
      end else if (active) begin
        osh_q   <= osh_q << step;
        io_o_q  <= lane_bits(osh_q, wid);
        obits_q <= obits_q - step;
      end else if (cyc_q == CYC_ADDR_END) begin
        ptr_q   <= addr_q[7:0];
      end
    end
  end

  // prefetch: byte n+1 is asked for as byte n starts shifting out
  always_ff @(negedge sck or negedge arst_n) begin
    if (!arst_n) begin
      rd_tog_q  <= 1'b0;
      rd_addr_q <= '0;
    end else if (rd_req) begin
      rd_tog_q  <= ~rd_tog_q;
      rd_addr_q <= {sr_sel, load ? ptr_q + 8'h01 : addr_q[7:0]};
    end
  end

  assign io_o  = io_o_q;
  assign io_oe = io_oe_q;

  // ==========================================================
  // core side on clk
  fid_mem_if   mif ();
  fid_erase_t  er_q, er_d;
  logic [11:0] ecnt_q;
  logic [1:0]  er_sel_q, h_sel;
  logic        cs_s1_q, cs_s2_q, cs_s3_q;
  logic        pg_s1_q, pg_s2_q, pg_s3_q;
  logic        rd_s1_q, rd_s2_q, rd_s3_q;
  logic        done_tog_q, busy_q, we_clr_q, post_rst_q;
  logic        cs_rise, pg_evt, rd_evt, cmd_new, can_write;
  logic        erase_go, lock_go, pg_ok, er_end;
  logic [LIW-1:0]         lock_idx;
  logic [LOCK_BLOCKS-1:0] block_lock_q, range_hit, prot_d, prot_q;
  logic [LIW:0]           prot_cnt;

  assign cs_rise  = cs_s2_q & ~cs_s3_q;
  assign pg_evt   = pg_s2_q ^ pg_s3_q;
  assign rd_evt   = rd_s2_q ^ rd_s3_q;
  // hold registers are quiet once sck has stopped and chip select is high
  assign cmd_new  = cs_rise && armed_q && (arm_tog_q != done_tog_q);
  assign h_sel    = secreg_sel(hold_addr_q);
  assign can_write = write_enable_latch && !busy_q;
  assign erase_go = cmd_new && hold_opc_q == OPC_SREG_ERASE && can_write &&
                    !sel_locked(h_sel, otp_lock_bits);
  assign lock_go  = cmd_new && hold_opc_q == OPC_BLK_LOCK && can_write;
  assign pg_ok    = pg_evt && can_write &&
                    !sel_locked(pg_addr_q[9:8], otp_lock_bits);
  assign lock_idx = hold_addr_q[16 +: LIW];
  assign er_end   = (er_q == ER_RUN) && (ecnt_q == ERASE_LAST);

  always_comb begin
    er_d = er_q;
    unique case (er_q)
      ER_IDLE: if (erase_go) er_d = ER_RUN;
      ER_RUN:  if (er_end) er_d = ER_IDLE;
    endcase
  end

  // erase rewrites the 256 bytes first, then waits out the erase time
  assign mif.we    = ((er_q == ER_RUN) && ecnt_q[11:8] == 4'h0) || pg_ok;
  assign mif.erase = (er_q == ER_RUN);
  assign mif.addr  = (er_q == ER_RUN) ? {er_sel_q, ecnt_q[7:0]} :
                     pg_ok ? pg_addr_q : rd_addr_q;
  assign mif.wdata = pg_data_q;
  assign mif.re    = rd_evt && !busy_q;
  assign core_rdata = mif.rdata;

  fid_secmem #(.DEPTH(1024)) u_store (
    .clk (clk),
    .m   (mif.store)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'b111;
      {pg_s1_q, pg_s2_q, pg_s3_q} <= 3'b000;
      {rd_s1_q, rd_s2_q, rd_s3_q} <= 3'b000;
    end else begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {cs_n, cs_s1_q, cs_s2_q};
      {pg_s1_q, pg_s2_q, pg_s3_q} <= {pg_tog_q, pg_s1_q, pg_s2_q};
      {rd_s1_q, rd_s2_q, rd_s3_q} <= {rd_tog_q, rd_s1_q, rd_s2_q};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      er_q        <= ER_IDLE;
      ecnt_q      <= '0;
      er_sel_q    <= '0;
      done_tog_q  <= 1'b0;
      busy_q      <= 1'b0;
      we_clr_q    <= 1'b0;
      post_rst_q  <= 1'b0;
    end else begin
      er_q        <= er_d;
      ecnt_q      <= (er_q == ER_RUN) ? ecnt_q + 12'h001 : 12'h000;
      if (erase_go) er_sel_q <= h_sel;
      // every frame end consumes its arm toggle, so a clockless frame cannot replay
      if (cs_rise) done_tog_q <= arm_tog_q;
      busy_q      <= (er_d == ER_RUN) | busy_other;
      we_clr_q    <= er_end;
      post_rst_q  <= 1'b1;
    end
  end

  // ==========================================================
  // block protection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      block_lock_q <= {LOCK_BLOCKS{BLOCK_LOCK_RST}};
      prot_q       <= {LOCK_BLOCKS{BLOCK_LOCK_RST}};
    end else begin
      if (lock_go) block_lock_q[lock_idx] <= 1'b1;
      prot_q <= prot_d;
    end
  end

  // sector granularity narrows ranges 1 to 6 to one end block
  assign prot_cnt = (protect_range_bits == 3'h0) ? '0 :
                    (protect_range_bits == 3'h7) ? (LIW+1)'(LOCK_BLOCKS) :
                    sector_granularity_select ? (LIW+1)'(1) :
                    (LIW+1)'(1) << (protect_range_bits - 3'h1);

  for (genvar b = 0; b < LOCK_BLOCKS; b++) begin : g_range
    assign range_hit[b] = top_bottom_select ? ((LIW+1)'(b) < prot_cnt)
                                            : ((LIW+1)'(LOCK_BLOCKS - b) <= prot_cnt);
  end

  assign prot_d = protection_scheme_select ? block_lock_q
                : (range_hit ^ {LOCK_BLOCKS{protect_complement}});

  assign block_protect = prot_q;
  assign busy          = busy_q;
  assign write_enable_clear = we_clr_q;
  assign erase_state   = er_q;

  // ==========================================================
  // checks
  erase_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    erase_go |=> busy_q [*8]) else $error("busy not held after erase start");
  erase_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(er_q) |-> we_clr_q && $past(ecnt_q) == ERASE_LAST)
    else $error("erase end without latch clear or wrong length");
  wren_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (erase_go || lock_go || (mif.we && !mif.erase)) |-> write_enable_latch)
    else $error("store changed without write enable");
  otp_guard_a: assert property (@(posedge clk) disable iff (!arst_n)
    mif.we |-> !sel_locked(mif.addr[9:8], otp_lock_bits))
    else $error("write to locked security register");
  secsel_a: assert property (@(posedge clk) disable iff (!arst_n)
    erase_go |-> hold_addr_q[11:8] == 4'h0 && hold_addr_q[15:12] != 4'h0)
    else $error("erase of illegal address");
  exact_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    erase_go |-> armed_q && $rose(cs_s2_q)) else $error("erase not at frame end");
  lock_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    lock_go |=> block_lock_q[$past(lock_idx)]) else $error("lock bit not set");
  lock_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    !post_rst_q |-> &block_lock_q) else $error("lock bits not set after reset");
  rd_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    busy_q |-> !mif.re) else $error("store read while busy");
  ptab_start_a: assert property (@(negedge sck) disable iff (!frame_rst_n)
    (opc_q == OPC_PTAB && cyc_q == CYC_STD_DATA) |=> io_oe == OE_SINGLE)
    else $error("table data not started at clock 40");
  quad_start_a: assert property (@(negedge sck) disable iff (!frame_rst_n)
    (opc_q == OPC_QUAD_ID && cyc_q == CYC_QUAD_DATA - 7'h01) |=> io_oe == 4'h0 ##1
    io_oe == OE_QUAD) else $error("quad id output timing");
  wrap_a: assert property (@(negedge sck) disable iff (!frame_rst_n)
    (opc_q == OPC_SREG_READ && load && ptr_q == 8'hff) |=> ptr_q == 8'h00)
    else $error("read address did not wrap");
endmodule

/* File: fid_host_model.sv */
// host serial controller model: chip select, serial clock, shared data lanes
`timescale 1ns/100ps
module fid_host_model (
  output logic            sck,
  output logic            cs_n,
  output wire logic [3:0] io_i,
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe
);
  logic [3:0] drv = 4'h5;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // ==========================================================
  // lanes: device wins where it drives, else host level
  for (genvar k = 0; k < 4; k++) begin : g_lane
    assign io_i[k] = io_oe[k] ? io_o[k] : drv[k];
  end
  task automatic step(input logic [3:0] v);
    drv = v;
    #62.5 sck = 1'b1;
    #62.5 sck = 1'b0;
  endtask
  // ==========================================================
  // one frame; an address bits at aw per clock, dm dummy clocks, nb bits read at dw
  task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input int an, aw, dm,
                      input int nb, dw, output logic [63:0] rd, output logic oe);
    rd = '0;
    oe = 1'b0;
    cs_n = 1'b0;  // low for the whole command
    for (int i = 7; i >= 0; i--) step({~drv[3:1], op[i]});
    for (int i = an - aw; i >= 0; i -= aw) step(4'((ad >> i) & ((1 << aw) - 1)));
    for (int i = 0; i < dm; i++) step((aw > 1 && i * aw < 4) ? 4'hf : ~drv);
    for (int j = 0; j < nb; j += dw) begin
      drv = ~drv;
      #62.5;
      rd = (rd << dw) | 64'((dw == 1) ? {3'h0, io_i[1]} : io_i & 4'((1 << dw) - 1));
      oe |= |io_oe;
      sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #400;
  endtask
endmodule

/* File: fid_cmd_top_bench.sv */
// self-checking bench for the id, security register and block lock commands
`timescale 1ns/100ps
module fid_cmd_top_bench;
  import fid_pkg::*;
  localparam logic [7:0]  MK  = 8'ha7;  // arbitrary value
  localparam logic [7:0]  PT  = 8'h3c;  // arbitrary value
  localparam logic [7:0]  MT  = 8'h61;  // arbitrary value
  localparam logic [7:0]  CP  = 8'h18;  // arbitrary value
  localparam logic [63:0] UID = 64'hfedc_ba98_7654_3210;  // arbitrary value
  logic        clk = 1'b0, arst_n = 1'b0, wren = 1'b0, pss = 1'b1;
  logic        inv = 1'b0, sgs = 1'b0, bot = 1'b0;
  logic [2:0]  lb = '0, rng = '0;
  wire logic   sck, cs_n;
  wire [3:0]   io_i, io_o, io_oe;
  logic        busy, we_clr, oe;
  fid_erase_t  est;
  logic [255:0] bprot;
  logic [63:0] rd;
  int          miscompares = 0, checks_done = 0, busy_cnt = 0, clr_cnt = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    busy_cnt += (busy === 1'b1);
    clr_cnt += (we_clr === 1'b1);
  end
  fid_cmd_top #(.MAKER_CODE(MK), .PART_CODE(PT), .MEM_TYPE(MT), .CAPACITY_CODE(CP),
    .UNIQUE_ID(UID)) i_dut (.clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n),
    .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .write_enable_latch(wren), .busy_other(1'b0),
    .otp_lock_bits(lb), .protection_scheme_select(pss), .protect_complement(inv),
    .sector_granularity_select(sgs), .top_bottom_select(bot), .protect_range_bits(rng),
    .busy(busy), .write_enable_clear(we_clr), .block_protect(bprot), .erase_state(est));
  fid_host_model i_host (.sck(sck), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
  // ==========================================================
  // shared checking and closing
  task automatic chk(input string nm, input logic [255:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("prot reset", bprot, '1);
    pss <= 1'b0;
    cyc(4);
    chk("prot range", bprot, '0);
    rng <= 3'h2;
    cyc(4);
    chk("prot top", bprot, {2'b11, 254'h0});
    inv <= 1'b1;
    cyc(4);
    chk("prot inv", bprot, ~{2'b11, 254'h0});
    inv <= 1'b0;
    bot <= 1'b1;
    cyc(4);
    chk("prot bottom", bprot, 256'h3);
    sgs <= 1'b1;
    cyc(4);
    chk("prot sector", bprot, 256'h1);
    {pss, sgs, bot, rng} <= 6'h20;
    cyc(4);
    chk("prot lock", bprot, '1);
  endtask
  task automatic t_ids;
    i_host.xfer(OPC_JEDEC, 0, 0, 1, 0, 24, 1, rd, oe);
    chk("jedec", rd, {MK, MT, CP});
    i_host.xfer(OPC_PTAB, 0, 24, 1, 8, 32, 1, rd, oe);
    chk("ptab", rd, 32'h5346_4450);
    i_host.xfer(OPC_UID, 0, 0, 1, 32, 64, 1, rd, oe);
    chk("uid", rd, UID);
    i_host.xfer(OPC_QUAD_ID, 0, 24, 4, 6, 16, 4, rd, oe);
    chk("quad id", rd, {MK, PT});
    i_host.xfer(OPC_DUAL_ID, 0, 24, 2, 4, 32, 2, rd, oe);
    chk("dual id", rd, {MK, PT, MK, PT});
  endtask
  task automatic t_erase;
    i_host.xfer(OPC_SREG_ERASE, 32'h001000, 24, 1, 0, 0, 1, rd, oe);
    chk("erase no wren", busy, 1'b0);
    cyc(1);
    wren <= 1'b1;
    lb <= 3'b001;
    i_host.xfer(OPC_SREG_ERASE, 32'h001000, 24, 1, 0, 0, 1, rd, oe);
    chk("erase locked", busy, 1'b0);
    cyc(1);
    lb <= 3'b000;
    i_host.xfer(OPC_SREG_ERASE, 32'h0010_0000, 32, 1, 0, 0, 1, rd, oe);
    chk("erase long", busy, 1'b0);
    busy_cnt = 0;
    clr_cnt = 0;
    i_host.xfer(OPC_SREG_ERASE, 32'h001000, 24, 1, 0, 0, 1, rd, oe);
    chk("erase busy", busy, 1'b1);
    chk("erase state", est, ER_RUN);
    i_host.xfer(OPC_SREG_READ, 32'h001000, 24, 1, 8, 8, 1, rd, oe);
    chk("read busy", oe, 1'b0);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    cyc(2);
    chk("erase len", busy_cnt, SECURITY_ERASE_CYCLES);
    chk("latch clear", clr_cnt, 1);
    chk("erase idle", est, ER_IDLE);
  endtask
  task automatic t_prog;
    i_host.xfer(OPC_SREG_PROG, 32'h0010_005a, 32, 1, 0, 0, 1, rd, oe);
    cyc(1);
    wren <= 1'b0;
    i_host.xfer(OPC_SREG_PROG, 32'h0010_0100, 32, 1, 0, 0, 1, rd, oe);
    cyc(1);
    wren <= 1'b1;
    lb <= 3'b001;
    i_host.xfer(OPC_SREG_PROG, 32'h0010_0200, 32, 1, 0, 0, 1, rd, oe);
    cyc(1);
    lb <= 3'b000;
    i_host.xfer(OPC_SREG_READ, 32'h0010ff, 24, 1, 8, 32, 1, rd, oe);
    chk("secreg read", rd, 32'hff5a_ffff);
  endtask
  task automatic t_lock;
    i_host.xfer(OPC_BLK_LOCK, 32'h120000, 24, 1, 0, 0, 1, rd, oe);
    cyc(2);
    chk("lock bit", bprot[8'h12], 1'b1);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(3);
    chk("prot reset again", bprot, '1);
  endtask
  initial begin
    cyc(4);
    arst_n <= 1'b1;
    cyc(3);
    t_reset;
    t_ids;
    t_erase;
    t_prog;
    t_lock;
    test_done;
  end
  initial begin
    #1_000_000;
    miscompares++;
    test_done;
  end
endmodule
